// file: src/rpu_pkg.sv
// Package: constants shared by the ROM patch unit files
package rpu_pkg;
    // ****************************************************************
    // Widths and counts
    // ****************************************************************
    localparam int ADDR_W = 16;
    localparam int WORD_W = 24;
    localparam int NUM_PATCH = 4;
    localparam int IDX_W = 2;
    // ****************************************************************
    // Patch window and jump encoding
    // ****************************************************************
    localparam logic [15:0] PATCH_ADDR_MAX = 16'h0100;
    localparam logic [15:0] TARGET_LIMIT = 16'h1000;
    localparam logic [15:0] PATCH_RESET_VAL = 16'h0000;
    localparam logic [23:0] WORD_RESET_VAL = 24'h000000;
    // Jump word layout: opcode in the top bits, 12-bit target below
    localparam int TARGET_W = 12;
    localparam int OPCODE_W = WORD_W - TARGET_W;
    localparam logic [11:0] JUMP_OPCODE = 12'h0c0;
    // Build-time jump destinations, one per comparator
    localparam logic [11:0] TARGET_0 = 12'h200;
    localparam logic [11:0] TARGET_1 = 12'h240;
    localparam logic [11:0] TARGET_2 = 12'h280;
    localparam logic [11:0] TARGET_3 = 12'h2c0;
endpackage

// file: src/rpu_match_if.sv
// Interface: comparator results passed from the matcher to the top
`timescale 1ns/1ps
interface rpu_match_if;
    logic hit;
    logic [1:0] hitIdx;
    modport matcher (output hit, output hitIdx);
    modport user (input hit, input hitIdx);
endinterface

// file: src/rpu_matcher.sv
// Module: four patch comparators with lowest-index priority
`timescale 1ns/1ps
module rpu_matcher #(
    parameter int NUM = 4
) (
    input wire logic [15:0] fetchAddr,
    input wire logic [NUM*16-1:0] patchAddrs,
    input wire logic [NUM-1:0] armed,
    rpu_match_if.matcher match
);
    always_comb begin
        match.hit = 1'b0;
        match.hitIdx = 2'h0;
        // Walk downward so the lowest matching register wins
        for (int i = NUM - 1; i >= 0; i--) begin
            if (armed[i] && patchAddrs[i*16 +: 16] == fetchAddr) begin
                match.hit = 1'b1;
                match.hitIdx = 2'(i);
            end
        end
    end
endmodule // rpu_matcher

// file: src/rpu_rom_patch_unit.sv
// Module: ROM patch unit on the instruction fetch path
`timescale 1ns/1ps
// How it works
// - Four patch address registers each feed their own comparator.
// - A fetch address equal to a patch register replaces the ROM word.
// - Equality raises matchHit and injects a jump into the pipeline.
// - Each comparator has its own jump destination.
// - Destinations are build-time constants below 4096.
// - Software reads and writes the registers; only $0000-$0100 are legal.
// - A register takes no part in comparison until written after reset.
module rpu_rom_patch_unit #(
    parameter logic [11:0] TARGET_0 = rpu_pkg::TARGET_0,
    parameter logic [11:0] TARGET_1 = rpu_pkg::TARGET_1,
    parameter logic [11:0] TARGET_2 = rpu_pkg::TARGET_2,
    parameter logic [11:0] TARGET_3 = rpu_pkg::TARGET_3
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [15:0] fetchAddressBus,
    input wire logic fetchValid,
    input wire logic [23:0] romData,
    input wire logic regWrite,
    input wire logic [1:0] regSel,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    output logic regWriteError,
    output logic [23:0] fetchDataBus,
    output logic matchHit,
    output logic [1:0] matchIdx
);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    localparam int NUM = rpu_pkg::NUM_PATCH;

    // Patching is confined to the low program window
    function automatic logic legalAddr(input logic [15:0] a);
        legalAddr = a <= rpu_pkg::PATCH_ADDR_MAX;
    endfunction

    // Shared by the register and arm groups so the two never disagree
    function automatic logic takesWrite(
        input logic we,
        input logic [1:0] sel,
        input logic [15:0] data,
        input logic [1:0] idx
    );
        takesWrite = we && legalAddr(data) && sel == idx;
    endfunction

    // Each comparator owns one destination fixed at build time
    function automatic logic [11:0] targetOf(input logic [1:0] idx);
        unique case (idx)
            2'h0: targetOf = TARGET_0;
            2'h1: targetOf = TARGET_1;
            2'h2: targetOf = TARGET_2;
            2'h3: targetOf = TARGET_3;
        endcase
    endfunction

    // The 12-bit target field keeps every destination below 4096
    function automatic logic [23:0] jumpWord(input logic [1:0] idx);
        jumpWord = {rpu_pkg::JUMP_OPCODE, targetOf(idx)};
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    // One entry per comparator
    logic [15:0] patchAddrRegs [NUM];
    logic [15:0] next_patchAddrRegs [NUM];
    logic [NUM-1:0] armed;
    logic [NUM-1:0] next_armed;
    logic next_regWriteError;
    logic [15:0] next_regRdata;
    logic [NUM*16-1:0] patchFlat;
    logic next_matchHit;
    logic [1:0] next_matchIdx;
    logic [23:0] next_fetchDataBus;

    // ****************************************************************
    // Patch address registers
    // ****************************************************************
    // A write lands at the next edge and takes part in comparison
    // from the fetch after it
    always_comb begin
        for (int i = 0; i < NUM; i++) begin
            next_patchAddrRegs[i] = patchAddrRegs[i];
            if (takesWrite(regWrite, regSel, regWdata, 2'(i))) begin
                next_patchAddrRegs[i] = regWdata;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < NUM; i++) begin
                patchAddrRegs[i] <= rpu_pkg::PATCH_RESET_VAL;
            end
        end else begin
            for (int i = 0; i < NUM; i++) begin
                patchAddrRegs[i] <= next_patchAddrRegs[i];
            end
        end
    end

    // ****************************************************************
    // Arm flags
    // ****************************************************************
    // Registers reset to address zero; without arming a fetch from
    // zero would hit every untouched comparator
    always_comb begin
        next_armed = armed;
        for (int i = 0; i < NUM; i++) begin
            if (takesWrite(regWrite, regSel, regWdata, 2'(i))) begin
                next_armed[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            armed <= '0;
        end else begin
            armed <= next_armed;
        end
    end

    // ****************************************************************
    // Write error pulse
    // ****************************************************************
    // An out-of-window write is dropped whole, so it never arms either
    always_comb begin
        next_regWriteError = regWrite && !legalAddr(regWdata);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            regWriteError <= 1'b0;
        end else begin
            regWriteError <= next_regWriteError;
        end
    end

    // ****************************************************************
    // Read-back
    // ****************************************************************
    // Follows the selector with one cycle of latency
    always_comb begin
        next_regRdata = patchAddrRegs[regSel];
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            regRdata <= rpu_pkg::PATCH_RESET_VAL;
        end else begin
            regRdata <= next_regRdata;
        end
    end

    // ****************************************************************
    // Comparators
    // ****************************************************************
    // Flattened so the matcher port stays a plain vector
    always_comb begin
        for (int i = 0; i < NUM; i++) begin
            patchFlat[i*16 +: 16] = patchAddrRegs[i];
        end
    end

    rpu_match_if matchBus ();

    rpu_matcher #(.NUM(NUM)) u_matcher (
        .fetchAddr(fetchAddressBus),
        .patchAddrs(patchFlat),
        .armed(armed),
        .match(matchBus.matcher)
    );

    // ****************************************************************
    // Match report
    // ****************************************************************
    // The index rests at zero unless a hit stands, so idle cycles read clean
    always_comb begin
        next_matchHit = fetchValid && matchBus.hit;
        next_matchIdx = 2'h0;
        if (next_matchHit) begin
            next_matchIdx = matchBus.hitIdx;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            matchHit <= 1'b0;
            matchIdx <= 2'h0;
        end else begin
            matchHit <= next_matchHit;
            matchIdx <= next_matchIdx;
        end
    end

    // ****************************************************************
    // Jump injection
    // ****************************************************************
    // Registered so the word lines up with the ROM's one-cycle read
    always_comb begin
        next_fetchDataBus = romData;
        if (fetchValid && matchBus.hit) begin
            next_fetchDataBus = jumpWord(matchBus.hitIdx);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fetchDataBus <= rpu_pkg::WORD_RESET_VAL;
        end else begin
            fetchDataBus <= next_fetchDataBus;
        end
    end
endmodule // rpu_rom_patch_unit

// file: bench/rpu_props.sv
// Checker: port assertions for the ROM patch unit
`timescale 1ns/1ps
module rpu_props (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [15:0] fetchAddressBus,
    input wire logic fetchValid,
    input wire logic [23:0] romData,
    input wire logic regWrite,
    input wire logic [1:0] regSel,
    input wire logic [15:0] regWdata,
    input wire logic [15:0] regRdata,
    input wire logic regWriteError,
    input wire logic [23:0] fetchDataBus,
    input wire logic matchHit,
    input wire logic [1:0] matchIdx
);
    logic wrote;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Any write since reset; before it no comparator may fire
    always_ff @(posedge clk_sys) wrote <= !reset && (wrote || regWrite);
    chk_read_back:
    assert property (regWrite && regWdata <= 16'h0100 ##1 $stable(regSel)
        |=> regRdata == $past(regWdata, 2)) else $error("read back");
    chk_jump_word:
    assert property (matchHit |-> fetchDataBus[23:12] == 12'h0c0)
        else $error("op");
    chk_rom_pass:
    assert property (fetchValid ##1 !matchHit
        |-> fetchDataBus == $past(romData)) else $error("rom word");
    chk_hit_cause:
    assert property (matchHit |-> $past(fetchValid)) else $error("stray hit");
    chk_target_pick:
    assert property (matchHit
        |-> fetchDataBus[11:0] == {4'h2, matchIdx, 6'h00})
        else $error("target");
    chk_bad_write:
    assert property (regWrite && regWdata > 16'h0100 |=> regWriteError)
        else $error("no error");
    chk_good_write:
    assert property (regWrite && regWdata <= 16'h0100 |=> !regWriteError)
        else $error("false error");
    chk_no_stale:
    assert property (!wrote |=> !matchHit) else $error("stale hit");
endmodule  // rpu_props
bind rpu_rom_patch_unit rpu_props props (.*);

// file: bench/rpu_fetch_model.sv
// Model: ROM behind the fetch path, one word per address
`timescale 1ns/1ps
module rpu_fetch_model (
    input wire logic [15:0] fetchAddressBus,
    output logic [23:0] romData
);
    // Address folded into the word so a replaced word is told apart
    assign romData = {8'h5a, fetchAddressBus};
endmodule  // rpu_fetch_model

// file: bench/tb_rpu_rom_patch_unit.sv
// Testbench: patch unit scenarios
`timescale 1ns/1ps
module tb_rpu_rom_patch_unit;
    logic clk_sys = 1'b0, reset = 1'b1, fetchValid = 1'b0, regWrite = 1'b0;
    logic [15:0] fetchAddressBus = '0, regWdata = '0, regRdata;
    logic [1:0] regSel = '0, matchIdx;
    logic [23:0] romData, fetchDataBus;
    logic regWriteError, matchHit;
    logic [11:0] tg [4] = '{rpu_pkg::TARGET_0, rpu_pkg::TARGET_1,
        rpu_pkg::TARGET_2, rpu_pkg::TARGET_3};
    int fail_count = 0, compares = 0;
    always #2.5 clk_sys = ~clk_sys;
    rpu_rom_patch_unit dut (.*);
    rpu_fetch_model rom (.fetchAddressBus(fetchAddressBus), .romData(romData));
    task automatic chk(string n, logic [23:0] s, e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [1:0] s, logic [15:0] d, logic err);
        @(posedge clk_sys) #1;
        {regWrite, regSel, regWdata} = {1'b1, s, d};
        @(posedge clk_sys) #1;
        regWrite = 1'b0;
        chk("err", 24'(regWriteError), 24'(err));
    endtask
    task automatic ft(logic [15:0] a, logic h, logic [1:0] i);
        @(posedge clk_sys) #1;
        {fetchValid, fetchAddressBus} = {1'b1, a};
        @(posedge clk_sys) #1;
        fetchValid = 1'b0;
        chk("hit", 24'(matchHit), 24'(h));
        chk("bus", fetchDataBus, h ? {12'h0c0, tg[i]} : {8'h5a, a});
        if (h)
            chk("idx", 24'(matchIdx), 24'(i));
    endtask
    task automatic rd(logic [1:0] s, logic [15:0] d);
        @(posedge clk_sys) #1;
        regSel = s;
        @(posedge clk_sys) #1;
        chk("rd", 24'(regRdata), 24'(d));
    endtask
    task automatic s_unarmed;
        ft(16'h0000, 1'b0, 2'h0);
        wr(2'h0, 16'h0040, 1'b0);
        ft(16'h0000, 1'b0, 2'h0);
        ft(16'h0040, 1'b1, 2'h0);
    endtask
    task automatic s_arm;
        logic [15:0] a [4] = '{16'h0010, 16'h0020, 16'h0030, 16'h0100};
        for (int i = 0; i < 4; i++)
            wr(2'(i), a[i], 1'b0);
        for (int i = 0; i < 4; i++) begin
            ft(a[i], 1'b1, 2'(i));
            ft({4'h0, tg[i]}, 1'b0, 2'h0);
            rd(2'(i), a[i]);
        end
        ft(16'h0011, 1'b0, 2'h0);
    endtask
    task automatic s_bad;
        wr(2'h1, 16'h0101, 1'b1);
        rd(2'h1, 16'h0020);
        ft(16'h0101, 1'b0, 2'h0);
    endtask
    task automatic s_prio;
        wr(2'h2, 16'h0010, 1'b0);
        ft(16'h0010, 1'b1, 2'h0);
        wr(2'h0, 16'h0050, 1'b0);
        ft(16'h0010, 1'b1, 2'h2);
    endtask
    task automatic s_reset;
        @(posedge clk_sys) #1 reset = 1'b1;
        @(posedge clk_sys) #1 reset = 1'b0;
        rd(2'h2, 16'h0000);
        ft(16'h0000, 1'b0, 2'h0);
    endtask
    task automatic complete_run;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        #1 reset = 1'b0;
        s_unarmed;
        s_arm;
        s_bad;
        s_prio;
        s_reset;
        complete_run;
    end
endmodule  // tb_rpu_rom_patch_unit
